// *** hw/flash_cmd_pkg.sv ***
// shared constants, states and carriers of the flash command and status logic
package flash_cmd_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W = 16;
	localparam int MAIN_N = 8;
	localparam int BOOT_N = 4;
	localparam int SEC_N  = MAIN_N + BOOT_N;
	localparam int TMR_W  = 13;

	// ==========================================================
	// instruction decode
	localparam logic [11:0] ADDR_UNLK1 = 12'h555;
	localparam logic [11:0] ADDR_UNLK2 = 12'haaa;
	localparam logic [7:0]  CMD_UNLK1  = 8'haa;
	localparam logic [7:0]  CMD_UNLK2  = 8'h55;
	localparam logic [7:0]  CMD_IDENT  = 8'h90;
	localparam logic [7:0]  CMD_PROG   = 8'ha0;
	localparam logic [7:0]  CMD_ERASE  = 8'h80;
	localparam logic [7:0]  CMD_SECTOR = 8'h30;
	localparam logic [7:0]  CMD_BULK   = 8'h10;
	localparam logic [7:0]  CMD_SUSP   = 8'hb0;
	localparam logic [7:0]  CMD_RESET  = 8'hf0;
	localparam logic [7:0]  CMD_BYPASS = 8'h20;
	localparam logic [7:0]  CMD_BYPEXT = 8'h00;

	// identifier read selectors on address bits 1..0
	localparam logic [1:0] SEL_ID   = 2'h1;
	localparam logic [1:0] SEL_PROT = 2'h2;
	localparam logic [7:0] PROT_YES = 8'h01;
	localparam logic [7:0] PROT_NO  = 8'h00;

	// ==========================================================
	// status byte layout
	localparam int POLL_POS  = 7;
	localparam int TOGG_POS  = 6;
	localparam int ERR_POS   = 5;
	localparam int EWIN_POS  = 3;

	// ==========================================================
	// timing
	localparam int CLK_MHZ        = 40;
	localparam int EWIN_US        = 100;
	localparam int EWIN_PCT       = 20;
	localparam int EWIN_CYC       = EWIN_US * CLK_MHZ * (100 + EWIN_PCT) / 100;
	localparam int PROT_ERASE_US  = 100;
	localparam int PROT_ERASE_CYC = PROT_ERASE_US * CLK_MHZ;
	localparam int GAP_US         = 80;
	localparam int GAP_CYC        = GAP_US * CLK_MHZ;

	// ==========================================================
	// decoder states
	typedef enum logic [4:0] {
		S_READ       = 5'h00,
		S_UNLK1      = 5'h01,
		S_UNLK2      = 5'h02,
		S_IDREAD     = 5'h03,
		S_PROG       = 5'h04,
		S_ER1        = 5'h05,
		S_ER2        = 5'h06,
		S_ER3        = 5'h07,
		S_EWIN       = 5'h08,
		S_BUSY_PROG  = 5'h09,
		S_BUSY_ERASE = 5'h0a,
		S_SUSPEND    = 5'h0b,
		S_BYPASS     = 5'h0c,
		S_BYP_PROG   = 5'h0d,
		S_BYP_RST    = 5'h0e,
		S_PROT_ERASE = 5'h0f,
		S_ERROR      = 5'h10
	} state_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic [MAIN_N-1:0] main_sel;
		logic [BOOT_N-1:0] boot_sel;
		logic              wr_n;
		logic              rd_n;
	} bus_t;

	typedef struct packed {
		logic              start_prog;
		logic              start_erase;
		logic              suspend;
		logic              resume;
		logic              abort;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic [SEC_N-1:0]  sectors;
	} op_t;

	localparam bus_t BUS_IDLE = '{addr: 16'h0000, wdata: 8'h00,
		main_sel: 8'h00, boot_sel: 4'h0, wr_n: 1'b1, rd_n: 1'b1};
	localparam op_t OP_IDLE = '{start_prog: 1'b0, start_erase: 1'b0,
		suspend: 1'b0, resume: 1'b0, abort: 1'b0, addr: 16'h0000,
		data: 8'h00, sectors: 12'h000};

endpackage

// *** hw/flash_timer.sv ***
// down-counting one-shot timer with a single-cycle expiry pulse
`timescale 1ns/1ps
module flash_timer #(
	parameter int WIDTH = 13
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_clk_en,
	input  wire logic             i_load,
	input  wire logic             i_clear,
	input  wire logic [WIDTH-1:0] i_count,
	output logic                  o_running,
	output logic                  o_expired
);
	logic [WIDTH-1:0] count;
	wire              last = o_running && (count == WIDTH'(1));

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count     <= '0;
			o_running <= 1'b0;
			o_expired <= 1'b0;
		end else if (i_clk_en) begin
			o_expired <= last && !i_load && !i_clear;
			if (i_clear) begin
				count     <= '0;
				o_running <= 1'b0;
			end else if (i_load) begin
				count     <= i_count;
				o_running <= 1'b1;
			end else if (o_running) begin
				count     <= count - WIDTH'(1);
				o_running <= !last;
			end
		end
	end
endmodule

// *** hw/flash_command_status_logic.sv ***
// instruction decoder and status reporting for the main and boot arrays
//
// Notes on behaviour
// - instruction addresses compare only bits 11..0.
// - after identifier read or error, only reset returns to array read.
// - protection read at bits 1..0 = 10 gives 01h protected, 00h not.
// - bypass program only after bypass entry; only bypass reset leaves.
// - suspend only while erasing, resume only while suspended.
// - decoder starts in array read mode after power-up.
// - reads outside instructions return array data.
// - identifier instruction: three writes then a read of fixed code.
// - status byte: poll 7, toggle 6, error 5, erase window 3.
// - poll bit reads inverted bit 7 of programmed byte while programming.
// - status valid after 4th write for program, 6th for erase.
// - poll bit reads 0 during erase, then true data.
// - program into a protected sector is ignored.
// - all-protected erase: no erase, status busy about 100 us.
// - toggle bit inverts on every selected read while busy.
// - error bit 0 while correct, 1 on failure.
// - error bit holds until the reset instruction.
// - window bit 0 for 120 us after each sector confirmation, then 1.
// - unlock is AAh at 555h then 55h at AAAh, then a command.
// - wrong byte or long gap returns decoding to array read.
// - bypass entered by unlock plus 20h, left by 90h then 00h.
`timescale 1ns/1ps
module flash_command_status_logic #(
	parameter int EWIN_CYCLES = flash_cmd_pkg::EWIN_CYC
) (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_nrst,
	input  wire logic                         i_clk_en,
	input  wire logic [flash_cmd_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [7:0]                   i_wdata,
	input  wire logic                         i_wr_n,
	input  wire logic                         i_rd_n,
	input  wire logic [flash_cmd_pkg::MAIN_N-1:0] i_main_array_selects,
	input  wire logic [flash_cmd_pkg::BOOT_N-1:0] i_boot_array_selects,
	input  wire logic [flash_cmd_pkg::SEC_N-1:0]  i_sector_protect,
	input  wire logic [7:0]                   i_array_rdata,
	input  wire logic                         i_op_done,
	input  wire logic                         i_op_fail,
	output logic [7:0]                        o_rdata,
	output logic                              o_rd_valid,
	output logic [flash_cmd_pkg::ADDR_W-1:0]  o_array_addr,
	output flash_cmd_pkg::op_t                o_op,
	output logic                              o_ready
);
	// ==========================================================
	// pin synchronisers
	flash_cmd_pkg::bus_t bus_s1;
	flash_cmd_pkg::bus_t bus_s2;
	logic                wr_d;
	logic                rd_d;
	logic                rd_d2;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bus_s1 <= flash_cmd_pkg::BUS_IDLE;
			bus_s2 <= flash_cmd_pkg::BUS_IDLE;
			wr_d   <= 1'b1;
			rd_d   <= 1'b1;
			rd_d2  <= 1'b1;
		end else if (i_clk_en) begin
			bus_s1 <= '{addr: i_addr, wdata: i_wdata,
				main_sel: i_main_array_selects,
				boot_sel: i_boot_array_selects,
				wr_n: i_wr_n, rd_n: i_rd_n};
			bus_s2 <= bus_s1;
			wr_d   <= bus_s2.wr_n;
			rd_d   <= bus_s2.rd_n;
			rd_d2  <= rd_d;
		end
	end

	// ==========================================================
	// decode
	flash_cmd_pkg::state_t state;
	flash_cmd_pkg::state_t next_state;
	flash_cmd_pkg::state_t home;

	logic                            error_bit;
	logic                            bypass;
	logic                            suspended;
	logic                            toggle_bit;
	logic [7:0]                      prog_data;
	logic [flash_cmd_pkg::SEC_N-1:0] erase_set;

	wire [flash_cmd_pkg::SEC_N-1:0] sel =
		{bus_s2.boot_sel, bus_s2.main_sel};
	wire        sel_any  = |sel;
	wire [11:0] a12      = bus_s2.addr[11:0];
	wire [7:0]  cmd      = bus_s2.wdata;
	wire        wr_ev    = i_clk_en && bus_s2.wr_n && !wr_d && sel_any;
	// read taken a cycle late so the array address register has caught up
	wire        rd_ev    = i_clk_en && !rd_d && rd_d2 && sel_any;
	wire        is_unlk1 = a12 == flash_cmd_pkg::ADDR_UNLK1 &&
		cmd == flash_cmd_pkg::CMD_UNLK1;
	wire        is_unlk2 = a12 == flash_cmd_pkg::ADDR_UNLK2 &&
		cmd == flash_cmd_pkg::CMD_UNLK2;
	wire        at_555   = a12 == flash_cmd_pkg::ADDR_UNLK1;
	wire        prot_hit = |(sel & i_sector_protect);
	wire        in_erase = |(sel & erase_set);
	wire [flash_cmd_pkg::SEC_N-1:0] bulk_set = bus_s2.main_sel != '0 ?
		{{flash_cmd_pkg::BOOT_N{1'b0}}, {flash_cmd_pkg::MAIN_N{1'b1}}} :
		{{flash_cmd_pkg::BOOT_N{1'b1}}, {flash_cmd_pkg::MAIN_N{1'b0}}};
	wire [flash_cmd_pkg::SEC_N-1:0] live_set =
		erase_set & ~i_sector_protect;

	wire mid_seq = state == flash_cmd_pkg::S_UNLK1 ||
		state == flash_cmd_pkg::S_UNLK2 || state == flash_cmd_pkg::S_PROG ||
		state == flash_cmd_pkg::S_ER1 || state == flash_cmd_pkg::S_ER2 ||
		state == flash_cmd_pkg::S_ER3 || state == flash_cmd_pkg::S_BYP_PROG ||
		state == flash_cmd_pkg::S_BYP_RST;
	wire busy_st = state == flash_cmd_pkg::S_BUSY_PROG ||
		state == flash_cmd_pkg::S_BUSY_ERASE ||
		state == flash_cmd_pkg::S_EWIN ||
		state == flash_cmd_pkg::S_PROT_ERASE;
	wire erase_st = state == flash_cmd_pkg::S_BUSY_ERASE ||
		state == flash_cmd_pkg::S_EWIN ||
		state == flash_cmd_pkg::S_PROT_ERASE;

	// ==========================================================
	// timers: gap between instruction bytes, erase window, dummy erase
	logic win_load;
	logic win_exp;
	logic prot_load;
	logic prot_exp;
	logic gap_exp;

	flash_timer #(.WIDTH(flash_cmd_pkg::TMR_W)) u_gap_timer (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_load    (wr_ev),
		.i_clear   (1'b0),
		.i_count   (flash_cmd_pkg::TMR_W'(flash_cmd_pkg::GAP_CYC)),
		.o_running (),
		.o_expired (gap_exp)
	);

	flash_timer #(.WIDTH(flash_cmd_pkg::TMR_W)) u_window_timer (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_load    (win_load),
		.i_clear   (state != flash_cmd_pkg::S_EWIN && !win_load),
		.i_count   (flash_cmd_pkg::TMR_W'(EWIN_CYCLES)),
		.o_running (),
		.o_expired (win_exp)
	);

	flash_timer #(.WIDTH(flash_cmd_pkg::TMR_W)) u_dummy_timer (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_load    (prot_load),
		.i_clear   (1'b0),
		.i_count   (flash_cmd_pkg::TMR_W'(flash_cmd_pkg::PROT_ERASE_CYC)),
		.o_running (),
		.o_expired (prot_exp)
	);

	// ==========================================================
	// next state
	logic start_prog;
	logic start_erase;
	logic go_susp;
	logic go_resume;
	logic do_abort;
	logic sec_add;
	logic bulk_add;
	logic set_bypass;
	logic clr_bypass;
	logic set_err;
	logic clr_err;

	// suspend and bypass are where an aborted sequence falls back to
	assign home = suspended ? flash_cmd_pkg::S_SUSPEND :
		bypass ? flash_cmd_pkg::S_BYPASS : flash_cmd_pkg::S_READ;

	always_comb begin
		next_state  = state;
		start_prog  = 1'b0;
		start_erase = 1'b0;
		go_susp     = 1'b0;
		go_resume   = 1'b0;
		do_abort    = 1'b0;
		sec_add     = 1'b0;
		bulk_add    = 1'b0;
		set_bypass  = 1'b0;
		clr_bypass  = 1'b0;
		set_err     = 1'b0;
		clr_err     = 1'b0;
		win_load    = 1'b0;
		prot_load   = 1'b0;
		case (state)
		flash_cmd_pkg::S_READ: begin
			if (wr_ev && is_unlk1)
				next_state = flash_cmd_pkg::S_UNLK1;
		end
		flash_cmd_pkg::S_SUSPEND: begin
			if (wr_ev && is_unlk1)
				next_state = flash_cmd_pkg::S_UNLK1;
			else if (wr_ev && cmd == flash_cmd_pkg::CMD_SECTOR) begin
				go_resume  = 1'b1;
				next_state = flash_cmd_pkg::S_BUSY_ERASE;
			end
		end
		flash_cmd_pkg::S_UNLK1: begin
			if (wr_ev)
				next_state = is_unlk2 ? flash_cmd_pkg::S_UNLK2 : home;
		end
		flash_cmd_pkg::S_UNLK2: begin
			if (wr_ev) begin
				next_state = home;
				if (at_555 && cmd == flash_cmd_pkg::CMD_IDENT)
					next_state = flash_cmd_pkg::S_IDREAD;
				else if (at_555 && cmd == flash_cmd_pkg::CMD_PROG)
					next_state = flash_cmd_pkg::S_PROG;
				else if (at_555 && cmd == flash_cmd_pkg::CMD_ERASE &&
						!suspended)
					next_state = flash_cmd_pkg::S_ER1;
				else if (at_555 && cmd == flash_cmd_pkg::CMD_BYPASS &&
						!suspended) begin
					set_bypass = 1'b1;
					next_state = flash_cmd_pkg::S_BYPASS;
				end
			end
		end
		flash_cmd_pkg::S_IDREAD: begin
			if (wr_ev && cmd == flash_cmd_pkg::CMD_RESET)
				next_state = home;
		end
		flash_cmd_pkg::S_PROG, flash_cmd_pkg::S_BYP_PROG: begin
			if (wr_ev) begin
				next_state = home;
				// suspended erase sectors and protected ones stay untouched
				if (!prot_hit && !(suspended && in_erase)) begin
					start_prog = 1'b1;
					next_state = flash_cmd_pkg::S_BUSY_PROG;
				end
			end
		end
		flash_cmd_pkg::S_ER1: begin
			if (wr_ev)
				next_state = is_unlk1 ? flash_cmd_pkg::S_ER2 : home;
		end
		flash_cmd_pkg::S_ER2: begin
			if (wr_ev)
				next_state = is_unlk2 ? flash_cmd_pkg::S_ER3 : home;
		end
		flash_cmd_pkg::S_ER3: begin
			if (wr_ev) begin
				next_state = home;
				if (cmd == flash_cmd_pkg::CMD_SECTOR) begin
					sec_add    = 1'b1;
					win_load   = 1'b1;
					next_state = flash_cmd_pkg::S_EWIN;
				end else if (at_555 && cmd == flash_cmd_pkg::CMD_BULK) begin
					bulk_add = 1'b1;
					if ((bulk_set & ~i_sector_protect) == '0) begin
						prot_load  = 1'b1;
						next_state = flash_cmd_pkg::S_PROT_ERASE;
					end else begin
						start_erase = 1'b1;
						next_state  = flash_cmd_pkg::S_BUSY_ERASE;
					end
				end
			end
		end
		flash_cmd_pkg::S_EWIN: begin
			if (wr_ev && cmd == flash_cmd_pkg::CMD_SECTOR) begin
				sec_add  = 1'b1;
				win_load = 1'b1;
			end else if (wr_ev && cmd != flash_cmd_pkg::CMD_SUSP)
				next_state = home;
			else if (win_exp) begin
				if (live_set == '0) begin
					prot_load  = 1'b1;
					next_state = flash_cmd_pkg::S_PROT_ERASE;
				end else begin
					start_erase = 1'b1;
					next_state  = flash_cmd_pkg::S_BUSY_ERASE;
				end
			end
		end
		flash_cmd_pkg::S_BUSY_PROG, flash_cmd_pkg::S_BUSY_ERASE: begin
			if (i_op_done) begin
				if (i_op_fail) begin
					set_err    = 1'b1;
					next_state = flash_cmd_pkg::S_ERROR;
				end else
					next_state = home;
			end else if (wr_ev && state == flash_cmd_pkg::S_BUSY_ERASE) begin
				if (cmd == flash_cmd_pkg::CMD_SUSP) begin
					go_susp    = 1'b1;
					next_state = flash_cmd_pkg::S_SUSPEND;
				end else if (cmd == flash_cmd_pkg::CMD_RESET) begin
					do_abort   = 1'b1;
					next_state = flash_cmd_pkg::S_READ;
				end
			end
		end
		flash_cmd_pkg::S_BYPASS: begin
			if (wr_ev && cmd == flash_cmd_pkg::CMD_PROG)
				next_state = flash_cmd_pkg::S_BYP_PROG;
			else if (wr_ev && cmd == flash_cmd_pkg::CMD_IDENT)
				next_state = flash_cmd_pkg::S_BYP_RST;
		end
		flash_cmd_pkg::S_BYP_RST: begin
			if (wr_ev && cmd == flash_cmd_pkg::CMD_BYPEXT) begin
				clr_bypass = 1'b1;
				next_state = flash_cmd_pkg::S_READ;
			end else if (wr_ev)
				next_state = flash_cmd_pkg::S_BYPASS;
		end
		flash_cmd_pkg::S_PROT_ERASE: begin
			if (prot_exp)
				next_state = home;
		end
		flash_cmd_pkg::S_ERROR: begin
			if (wr_ev && cmd == flash_cmd_pkg::CMD_RESET) begin
				clr_err    = 1'b1;
				next_state = home;
			end
		end
		default: next_state = flash_cmd_pkg::S_READ;
		endcase
		// a stalled host loses the half-entered instruction
		if (gap_exp && mid_seq && !wr_ev)
			next_state = home;
	end

	// ==========================================================
	// read data
	// identifier value is arbitrary
	localparam logic [7:0] ID_CODE = 8'h5a;

	wire poll_bit = erase_st ? 1'b0 : ~prog_data[7];
	wire [7:0] status_byte = {poll_bit, toggle_bit, error_bit, 1'b0,
		state != flash_cmd_pkg::S_EWIN, 3'b000};
	wire [7:0] id_byte = bus_s2.addr[1:0] == flash_cmd_pkg::SEL_ID ?
		ID_CODE : bus_s2.addr[1:0] == flash_cmd_pkg::SEL_PROT ?
		(prot_hit ? flash_cmd_pkg::PROT_YES : flash_cmd_pkg::PROT_NO) :
		i_array_rdata;
	wire [7:0] next_rdata = (busy_st || state == flash_cmd_pkg::S_ERROR) ?
		status_byte : state == flash_cmd_pkg::S_IDREAD ? id_byte :
		i_array_rdata;

	// ==========================================================
	// registers
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state       <= flash_cmd_pkg::S_READ;
			error_bit   <= 1'b0;
			bypass      <= 1'b0;
			suspended   <= 1'b0;
			toggle_bit  <= 1'b0;
			prog_data   <= 8'h00;
			erase_set   <= '0;
			o_rdata     <= 8'h00;
			o_rd_valid  <= 1'b0;
			o_op        <= flash_cmd_pkg::OP_IDLE;
			o_ready     <= 1'b1;
		end else if (i_clk_en) begin
			state      <= next_state;
			o_rd_valid <= rd_ev;
			o_ready    <= !busy_st;
			if (rd_ev)
				o_rdata <= next_rdata;
			if (rd_ev && busy_st)
				toggle_bit <= !toggle_bit;
			if (set_err)
				error_bit <= 1'b1;
			else if (clr_err)
				error_bit <= 1'b0;
			if (set_bypass)
				bypass <= 1'b1;
			else if (clr_bypass)
				bypass <= 1'b0;
			if (go_susp)
				suspended <= 1'b1;
			else if (go_resume || do_abort)
				suspended <= 1'b0;
			if (start_prog)
				prog_data <= cmd;
			if (bulk_add)
				erase_set <= bulk_set;
			else if (sec_add)
				erase_set <= (state == flash_cmd_pkg::S_ER3 ? '0 : erase_set)
					| sel;
			o_op.start_prog  <= start_prog;
			o_op.start_erase <= start_erase;
			o_op.suspend     <= go_susp;
			o_op.resume      <= go_resume;
			o_op.abort       <= do_abort;
			if (start_prog) begin
				o_op.addr    <= bus_s2.addr;
				o_op.data    <= cmd;
				o_op.sectors <= sel;
			end else if (start_erase)
				o_op.sectors <= bulk_add ? bulk_set : live_set;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_array_addr <= '0;
		else if (i_clk_en)
			o_array_addr <= bus_s2.addr;
	end

	// ==========================================================
	// checks
	a_poll_in_erase: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && state == flash_cmd_pkg::S_BUSY_ERASE |=> !o_rdata[7])
		else $error("poll bit not low during erase");

	a_poll_in_prog: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && state == flash_cmd_pkg::S_BUSY_PROG
		|=> o_rdata[7] == ~prog_data[7])
		else $error("poll bit not inverted during program");

	a_id_value: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && state == flash_cmd_pkg::S_IDREAD &&
		bus_s2.addr[1:0] == flash_cmd_pkg::SEL_ID |=> o_rdata == ID_CODE)
		else $error("identifier read wrong");

	a_prot_value: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && state == flash_cmd_pkg::S_IDREAD && prot_hit &&
		bus_s2.addr[1:0] == flash_cmd_pkg::SEL_PROT
		|=> o_rdata == flash_cmd_pkg::PROT_YES)
		else $error("protection read wrong");

	a_error_holds: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		error_bit && !(wr_ev && cmd == flash_cmd_pkg::CMD_RESET)
		|=> error_bit)
		else $error("error bit dropped without reset");

	a_toggle_flips: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && busy_st |=> toggle_bit != $past(toggle_bit))
		else $error("toggle bit did not invert");

	a_prot_prog_ignored: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		wr_ev && state == flash_cmd_pkg::S_PROG && prot_hit
		|=> !o_op.start_prog ##1 !o_op.start_prog)
		else $error("program into protected sector started");

	a_bypass_needed: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		state == flash_cmd_pkg::S_BYP_PROG |-> bypass)
		else $error("bypass program without bypass entry");

	a_suspend_valid: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		$rose(o_op.suspend) |-> $past(state) ==
		flash_cmd_pkg::S_BUSY_ERASE && state == flash_cmd_pkg::S_SUSPEND)
		else $error("suspend outside sector erase");

	a_window_bit: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rd_ev && state == flash_cmd_pkg::S_EWIN |=> !o_rdata[3])
		else $error("window bit high inside window");

endmodule

// *** tb/flash_engine_model.sv ***
// program/erase engine and array model behind the command logic
`timescale 1ns/1ps
module flash_engine_model #(
	parameter int DELAY = 150
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_nrst,
	input  wire flash_cmd_pkg::op_t i_op,
	input  wire logic [15:0]        i_array_addr,
	input  wire logic               i_fail_req,
	output logic                    o_done,
	output logic                    o_fail,
	output logic [7:0]              o_rdata
);
	// ==========================================================
	// engine
	logic [8:0] cnt;
	logic       busy;
	logic       hold;

	// address-dependent contents, so a stale byte cannot pass
	assign o_rdata = ~i_array_addr[7:0];
	assign o_done  = busy && !hold && cnt == 9'h001;
	assign o_fail  = o_done && i_fail_req;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy <= 1'b0;
			hold <= 1'b0;
			cnt  <= 9'h000;
		end else if (i_op.start_prog || i_op.start_erase) begin
			busy <= 1'b1;
			hold <= 1'b0;
			cnt  <= 9'(DELAY);
		end else if (i_op.abort || o_done) begin
			busy <= 1'b0;
			hold <= 1'b0;
		end else if (i_op.suspend) begin
			hold <= 1'b1;
		end else if (i_op.resume) begin
			hold <= 1'b0;
		end else if (busy && !hold) begin
			cnt <= cnt - 9'h001;
		end
	end
endmodule

// *** tb/flash_command_status_logic_tb.sv ***
// self-checking bench for the flash command and status logic
`timescale 1ns/1ps
module flash_command_status_logic_tb;
	// ==========================================================
	// signals
	logic               i_sys_clk = 1'b0;
	logic               i_nrst = 1'b0;
	logic [15:0]        addr = 16'h0000;
	logic [7:0]         wdata = 8'h00;
	logic               wr_n = 1'b1;
	logic               rd_n = 1'b1;
	logic               fail_req = 1'b0;
	logic [7:0]         msel = 8'h00;
	logic [7:0]         q, t1, ard, rdata, st_data;
	logic [7:0]         n_start = 8'h00;
	logic [15:0]        aaddr;
	logic               done, fail, rdy, rv, rq;
	flash_cmd_pkg::op_t op;
	int                 failures = 0;
	int                 n_tests = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;

	flash_command_status_logic #(.EWIN_CYCLES(40))
		i_flash_command_status_logic (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(1'b1),
		.i_addr(addr), .i_wdata(wdata), .i_wr_n(wr_n), .i_rd_n(rd_n),
		.i_main_array_selects(msel), .i_boot_array_selects(4'h0),
		.i_sector_protect(12'h001), .i_array_rdata(ard),
		.i_op_done(done), .i_op_fail(fail), .o_rdata(rdata),
		.o_rd_valid(rv), .o_array_addr(aaddr), .o_op(op), .o_ready(rdy));

	flash_engine_model i_flash_engine_model (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_op(op),
		.i_array_addr(aaddr), .i_fail_req(fail_req), .o_done(done),
		.o_fail(fail), .o_rdata(ard));

	always @(negedge i_sys_clk) begin
		if (op.start_prog === 1'b1) begin
			n_start = n_start + 8'h01;
			st_data = op.data;
		end
	end

	// ==========================================================
	// tasks
	task automatic test_done;
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// strobes go through synchronisers, so hold each phase 4 clocks
	task automatic wr(input logic [15:0] a, input logic [7:0] d, s);
		@(posedge i_sys_clk);
		addr  <= a;
		wdata <= d;
		msel  <= s;
		wr_n  <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		msel <= 8'h00;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] s);
		int k;
		k = 0;
		@(posedge i_sys_clk);
		addr <= a;
		msel <= s;
		rd_n <= 1'b0;
		do begin
			@(negedge i_sys_clk);
			k++;
		end while (rv !== 1'b1 && k < 20);
		q = rdata;
		rq = rdy;
		if (rv !== 1'b1) begin
			failures++;
			test_done;
		end
		@(posedge i_sys_clk);
		rd_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		msel <= 8'h00;
	endtask

	task automatic unl(input logic [7:0] c, s);
		wr(16'h0555, 8'haa, s);
		wr(16'h0aaa, 8'h55, s);
		wr(16'h0555, c, s);
	endtask

	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		rd(16'h0123, 8'h01);
		chk("array read", 8'hdc, q);
		wr(16'hf555, 8'haa, 8'h01);
		wr(16'h3aaa, 8'h55, 8'h01);
		wr(16'h7555, flash_cmd_pkg::CMD_IDENT, 8'h01);
		rd(16'h0001, 8'h01);
		// identifier value is arbitrary for this block
		chk("ident", 8'h5a, q);
		rd(16'h0002, 8'h01);
		chk("protected", 8'h01, q);
		rd(16'h0002, 8'h02);
		chk("unprotected", 8'h00, q);
		wr(16'h0000, flash_cmd_pkg::CMD_RESET, 8'h01);
		rd(16'h0044, 8'h01);
		chk("after reset", 8'hbb, q);
		wr(16'h0555, 8'haa, 8'h02);
		wr(16'h0aaa, 8'h12, 8'h02);
		rd(16'h0066, 8'h02);
		chk("bad byte", 8'h99, q);
		unl(flash_cmd_pkg::CMD_PROG, 8'h02);
		wr(16'h1234, 8'h80, 8'h02);
		chk("prog data", 8'h80, st_data);
		rd(16'h1234, 8'h02);
		t1 = q;
		chk("poll", 8'h08, q & 8'ha8);
		chk("busy", 8'h00, {7'h00, rq});
		rd(16'h1234, 8'h02);
		chk("toggle", {7'h00, ~t1[6]}, {7'h00, q[6]});
		repeat (200) @(posedge i_sys_clk);
		rd(16'h1234, 8'h02);
		chk("prog done", 8'hcb, q);
		chk("ready", 8'h01, {7'h00, rq});
		unl(flash_cmd_pkg::CMD_PROG, 8'h01);
		wr(16'h0010, 8'h00, 8'h01);
		repeat (20) @(posedge i_sys_clk);
		chk("prot prog", 8'h01, n_start);
		fail_req <= 1'b1;
		unl(flash_cmd_pkg::CMD_PROG, 8'h02);
		wr(16'h0020, 8'h7f, 8'h02);
		repeat (200) @(posedge i_sys_clk);
		rd(16'h0020, 8'h02);
		chk("error", 8'h20, q & 8'h20);
		rd(16'h0020, 8'h02);
		chk("error held", 8'h20, q & 8'h20);
		fail_req <= 1'b0;
		wr(16'h0000, flash_cmd_pkg::CMD_RESET, 8'h02);
		rd(16'h0020, 8'h02);
		chk("error cleared", 8'hdf, q);
		unl(flash_cmd_pkg::CMD_ERASE, 8'h02);
		wr(16'h0555, 8'haa, 8'h02);
		wr(16'h0aaa, 8'h55, 8'h02);
		wr(16'h0300, flash_cmd_pkg::CMD_SECTOR, 8'h02);
		rd(16'h0300, 8'h02);
		chk("window", 8'h00, q & 8'ha8);
		wr(16'h0400, flash_cmd_pkg::CMD_SECTOR, 8'h04);
		repeat (60) @(posedge i_sys_clk);
		rd(16'h0300, 8'h02);
		chk("erasing", 8'h08, q & 8'ha8);
		chk("sectors", 8'h06, op.sectors[7:0]);
		wr(16'h0000, flash_cmd_pkg::CMD_SUSP, 8'h02);
		rd(16'h0055, 8'h08);
		chk("suspended read", 8'haa, q);
		wr(16'h0000, flash_cmd_pkg::CMD_SECTOR, 8'h02);
		rd(16'h0300, 8'h02);
		chk("resumed", 8'h08, q & 8'ha8);
		repeat (200) @(posedge i_sys_clk);
		rd(16'h0300, 8'h02);
		chk("erased", 8'hff, q);
		unl(flash_cmd_pkg::CMD_BYPASS, 8'h02);
		wr(16'h0000, flash_cmd_pkg::CMD_PROG, 8'h02);
		wr(16'h0040, 8'h55, 8'h02);
		repeat (200) @(posedge i_sys_clk);
		chk("bypass prog", 8'h03, n_start);
		wr(16'h0000, flash_cmd_pkg::CMD_IDENT, 8'h02);
		wr(16'h0000, flash_cmd_pkg::CMD_BYPEXT, 8'h02);
		wr(16'h0000, flash_cmd_pkg::CMD_PROG, 8'h02);
		wr(16'h0050, 8'h11, 8'h02);
		repeat (20) @(posedge i_sys_clk);
		chk("bypass exit", 8'h03, n_start);
		test_done;
	end
endmodule
